// *** fg_guard.sv ***
// flash self-programming access guard with wishbone registers
// ------------------------------------------------------------
// Notes on behaviour
// - programming concurrent section keeps core running, halting section stays readable
// - programming halting section halts core until the operation ends
// - concurrent section unreadable by any means while programming it
// - section busy flag reads one while concurrent section is blocked
// - boot section always lies inside halting section
// - lock bits set by software or programming port, cleared by chip erase
// - general write lock ignored by program store
// - general read/write lock ignored by program load and store
// - app lock mode 1 places no restriction on application section
// - app lock mode 2 rejects stores, allows loads
// - app lock mode 3 rejects stores and loads from boot code
// - app lock mode 4 rejects loads from boot code, allows stores
// - app modes 3/4, vectors in boot: interrupts off running app code
// - boot lock mode 1 places no restriction on boot section
// - boot lock mode 2 rejects stores, allows loads
// - boot lock mode 3 rejects stores and loads from app code
// - boot lock mode 4 rejects loads from app code, allows stores
// - boot modes 3/4, vectors in app: interrupts off running boot code
// - busy flag cleared by read re-enable after op, or buffer load start
// ------------------------------------------------------------
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module fg_guard
	import fg_pkg::*;
#(
	parameter int              AW         = 12,
	parameter logic [AW-1:0]   HALT_START = 12'hC00,
	parameter logic [AW-1:0]   BOOT_MIN   = 12'h080
)(
	// clock, reset, enable
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	// wishbone slave
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [7:0]    adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	output logic      [31:0]   dat_o,
	output logic               ack_o,
	// core requests
	input  wire logic          op_req_i,
	input  wire logic [1:0]    op_kind_i,
	input  wire logic [AW-1:0] op_addr_i,
	input  wire logic          exec_in_boot_i,
	input  wire logic [AW-1:0] fetch_addr_i,
	// flash engine
	input  wire logic          flash_done_i,
	output logic               flash_start_o,
	output logic               flash_erase_o,
	output logic      [AW-1:0] flash_addr_o,
	output logic               read_grant_o,
	// fuses and programming port
	input  wire logic [1:0]    boot_size_select_i,
	input  wire logic          chip_erase_i,
	input  wire logic          ext_lock_we_i,
	input  wire logic [3:0]    ext_lock_dat_i,
	// core control
	output logic               cpu_halt_o,
	output logic               fetch_block_o,
	output logic               irq_block_o,
	output logic               section_busy_flag_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		fg_state_t     st;
		logic [AW-1:0] addr;
		logic          erase;
		logic          busy;
		logic [3:0]    lock;
		logic          vec_boot;
		logic          rej_st;
		logic          rej_ld;
		logic          start;
		logic          rgrant;
		logic          ack;
		logic [31:0]   dat;
	} fg_regs_t;

	fg_regs_t r_reg;
	fg_regs_t r_next;

	// ------------------------------------------------------------
	// section decode
	// ------------------------------------------------------------
	localparam logic [AW:0] FLASH_WORDS = {1'b1, {AW{1'b0}}};

	logic [AW-1:0] boot_start;
	logic [AW:0]   boot_len;

	always_comb
	begin
		boot_len = {1'b0, BOOT_MIN} << (2'h3 - boot_size_select_i);
		boot_start = AW'(FLASH_WORDS - boot_len);
		if (boot_len > {1'b0, ~HALT_START} + 1'b1)
			boot_start = HALT_START;
	end

	function automatic logic in_boot(input logic [AW-1:0] a);
		return a >= boot_start;
	endfunction

	function automatic logic in_crs(input logic [AW-1:0] a);
		return a < HALT_START;
	endfunction

	// ------------------------------------------------------------
	// lock checks (general lock modes never consulted)
	// ------------------------------------------------------------
	logic app_lo;
	logic app_up;
	logic boot_lo;
	logic boot_up;

	assign app_lo  = r_reg.lock[FG_LK_APP_LO];
	assign app_up  = r_reg.lock[FG_LK_APP_UP];
	assign boot_lo = r_reg.lock[FG_LK_BOOT_LO];
	assign boot_up = r_reg.lock[FG_LK_BOOT_UP];

	function automatic logic store_ok(input logic [AW-1:0] a);
		if (in_boot(a))
			return boot_lo;
		return app_lo;
	endfunction

	function automatic logic load_ok(input logic [AW-1:0] a);
		if (in_boot(a))
			return boot_up || exec_in_boot_i;
		return app_up || !exec_in_boot_i;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic bus_req;
	logic bus_wr;
	logic idle;
	logic is_prog;

	assign bus_req = cyc_i && stb_i && !r_reg.ack;
	assign bus_wr  = bus_req && we_i && sel_i[0];
	assign idle    = r_reg.st == FG_ST_IDLE;
	assign is_prog = op_kind_i == FG_OP_ERASE || op_kind_i == FG_OP_WRITE;

	always_comb
	begin
		r_next = r_reg;
		r_next.start = 1'b0;
		r_next.rgrant = 1'b0;
		r_next.ack = bus_req;
		r_next.dat = FG_ZERO32;

		// bus reads
		if (bus_req && !we_i)
		begin
			unique case (adr_i)
				FG_OFS_CTRL: r_next.dat[FG_CTRL_VEC] = r_reg.vec_boot;
				FG_OFS_LOCK: r_next.dat[3:0] = r_reg.lock;
				FG_OFS_STAT:
				begin
					r_next.dat[FG_ST_BUSY]   = r_reg.busy;
					r_next.dat[FG_ST_HALT]   = r_reg.st == FG_ST_HLT;
					r_next.dat[FG_ST_ACTIVE] = !idle;
					r_next.dat[FG_ST_REJ_ST] = r_reg.rej_st;
					r_next.dat[FG_ST_REJ_LD] = r_reg.rej_ld;
				end
				default: r_next.dat = FG_ZERO32;
			endcase
		end

		// bus writes: clears first so that events below win
		if (bus_wr && adr_i == FG_OFS_CTRL)
		begin
			r_next.vec_boot = dat_i[FG_CTRL_VEC];
			if (dat_i[FG_CTRL_REEN] && idle)
				r_next.busy = 1'b0;
		end
		if (bus_wr && adr_i == FG_OFS_LOCK)
			r_next.lock = r_reg.lock & dat_i[3:0];
		if (bus_wr && adr_i == FG_OFS_STAT)
		begin
			if (dat_i[FG_ST_REJ_ST])
				r_next.rej_st = 1'b0;
			if (dat_i[FG_ST_REJ_LD])
				r_next.rej_ld = 1'b0;
		end
		if (ext_lock_we_i)
			r_next.lock = r_next.lock & ext_lock_dat_i;

		// operation end
		if (!idle && flash_done_i)
			r_next.st = FG_ST_IDLE;

		// core requests
		if (op_req_i && idle)
		begin
			if (is_prog)
			begin
				if (store_ok(op_addr_i))
				begin
					r_next.addr = op_addr_i;
					r_next.erase = op_kind_i == FG_OP_ERASE;
					r_next.start = 1'b1;
					if (in_crs(op_addr_i))
					begin
						r_next.st = FG_ST_CRS;
						r_next.busy = 1'b1;
					end
					else
						r_next.st = FG_ST_HLT;
				end
				else
					r_next.rej_st = 1'b1;
			end
			else if (op_kind_i == FG_OP_BUFLOAD)
				r_next.busy = 1'b0;
			else if (load_ok(op_addr_i) && !(r_reg.busy && in_crs(op_addr_i)))
				r_next.rgrant = 1'b1;
			else
				r_next.rej_ld = 1'b1;
		end
		else if (op_req_i && op_kind_i == FG_OP_READ)
		begin
			if (load_ok(op_addr_i) && !in_crs(op_addr_i))
				r_next.rgrant = 1'b1;
			else
				r_next.rej_ld = 1'b1;
		end

		if (chip_erase_i)
			r_next.lock = FG_LOCK_RST;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r_reg.st <= FG_ST_IDLE;
			r_reg.addr <= '0;
			r_reg.erase <= 1'b0;
			r_reg.busy <= 1'b0;
			r_reg.lock <= FG_LOCK_RST;
			r_reg.vec_boot <= 1'b0;
			r_reg.rej_st <= 1'b0;
			r_reg.rej_ld <= 1'b0;
			r_reg.start <= 1'b0;
			r_reg.rgrant <= 1'b0;
			r_reg.ack <= 1'b0;
			r_reg.dat <= FG_ZERO32;
		end
		else if (ce_i)
			r_reg <= r_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic exec_app_blocked;
	logic exec_boot_blocked;

	assign exec_app_blocked  = !app_up && r_reg.vec_boot && !exec_in_boot_i;
	assign exec_boot_blocked = !boot_up && !r_reg.vec_boot && exec_in_boot_i;

	assign dat_o = r_reg.dat;
	assign ack_o = r_reg.ack;
	assign flash_start_o = r_reg.start;
	assign flash_erase_o = r_reg.erase;
	assign flash_addr_o = r_reg.addr;
	assign read_grant_o = r_reg.rgrant;
	assign cpu_halt_o = r_reg.st == FG_ST_HLT;
	assign fetch_block_o = r_reg.busy && in_crs(fetch_addr_i);
	assign irq_block_o = exec_app_blocked || exec_boot_blocked;
	assign section_busy_flag_o = r_reg.busy;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic acc_prog;
	assign acc_prog = ce_i && op_req_i && idle && is_prog && store_ok(op_addr_i);

	a_crs_run: assert property (acc_prog && in_crs(op_addr_i) |=>
		!cpu_halt_o && section_busy_flag_o && flash_start_o)
		else $error("concurrent section op halted core or left busy low");

	a_halt_sec: assert property (acc_prog && !in_crs(op_addr_i) |=>
		cpu_halt_o throughout (!flash_done_i || !ce_i)[*1])
		else $error("halting section op did not halt core");

	a_halt_hold: assert property (cpu_halt_o && !(flash_done_i && ce_i) |=>
		cpu_halt_o)
		else $error("halt dropped before operation end");

	a_fetch_block: assert property (section_busy_flag_o && in_crs(fetch_addr_i) |->
		fetch_block_o)
		else $error("fetch of blocked section not blocked");

	a_busy_read: assert property (ce_i && op_req_i && op_kind_i == FG_OP_READ
		&& section_busy_flag_o && in_crs(op_addr_i) |=> !read_grant_o)
		else $error("load of blocked section granted");

	a_reenable: assert property (ce_i && idle && bus_wr && adr_i == FG_OFS_CTRL
		&& dat_i[FG_CTRL_REEN] && !(op_req_i && is_prog) |=> !section_busy_flag_o)
		else $error("read re-enable did not clear busy flag");

	a_bufload_clr: assert property (ce_i && idle && op_req_i
		&& op_kind_i == FG_OP_BUFLOAD |=> !section_busy_flag_o)
		else $error("buffer load did not clear busy flag");

	a_rej_store: assert property (ce_i && idle && op_req_i && is_prog
		&& !store_ok(op_addr_i) |=> !flash_start_o && r_reg.rej_st)
		else $error("rejected store started flash");

	a_lock_set_only: assert property (!$past(chip_erase_i) |->
		(r_reg.lock & ~$past(r_reg.lock)) == 4'h0)
		else $error("lock bit returned to unprogrammed without chip erase");

	a_boot_in_halt: assert property (boot_start >= HALT_START)
		else $error("boot section reaches concurrent section");

	a_irq_app: assert property (!app_up && r_reg.vec_boot && !exec_in_boot_i
		|-> irq_block_o)
		else $error("interrupts not blocked in app code");

	a_irq_boot: assert property (!boot_up && !r_reg.vec_boot && exec_in_boot_i
		|-> irq_block_o)
		else $error("interrupts not blocked in boot code");

	a_bus_ack: assert property (ce_i && bus_req |=> ack_o ##1 (!ack_o || !ce_i))
		else $error("bus ack not one cycle");

	a_rej_load: assert property (ce_i && idle && op_req_i
		&& op_kind_i == FG_OP_READ && !load_ok(op_addr_i) |=> !read_grant_o && r_reg.rej_ld)
		else $error("lock-rejected load was granted");

	a_addr_hold: assert property (!idle |=>
		$stable(flash_addr_o))
		else $error("latched flash address changed during operation");

	a_one_op: assert property (!idle && ce_i |=>
		!flash_start_o)
		else $error("second operation started before the first ended");

	a_halt_end: assert property (cpu_halt_o && flash_done_i && ce_i |=>
		!cpu_halt_o)
		else $error("halt held past operation end");

	c_crs_op: cover property (acc_prog && in_crs(op_addr_i) ##[1:20] flash_done_i);
	c_halt_op: cover property (cpu_halt_o ##[1:20] !cpu_halt_o);
	c_rej_ld: cover property (ce_i && op_req_i && op_kind_i == FG_OP_READ
		&& !load_ok(op_addr_i));
	c_reen: cover property (section_busy_flag_o ##[1:50] !section_busy_flag_o);
	c_rej_st: cover property (ce_i && idle && op_req_i && is_prog
		&& !store_ok(op_addr_i));

endmodule // fg_guard

`default_nettype wire

// *** fg_pkg.sv ***
// shared constants for the self-programming flash access guard
package fg_pkg;

	// ------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] FG_OFS_CTRL = 8'h00;
	localparam logic [7:0] FG_OFS_LOCK = 8'h04;
	localparam logic [7:0] FG_OFS_STAT = 8'h08;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FG_CTRL_REEN  = 0;
	localparam int FG_CTRL_VEC   = 1;
	localparam int FG_LK_APP_LO  = 0;
	localparam int FG_LK_APP_UP  = 1;
	localparam int FG_LK_BOOT_LO = 2;
	localparam int FG_LK_BOOT_UP = 3;
	localparam int FG_ST_BUSY    = 0;
	localparam int FG_ST_HALT    = 1;
	localparam int FG_ST_ACTIVE  = 2;
	localparam int FG_ST_REJ_ST  = 3;
	localparam int FG_ST_REJ_LD  = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  FG_LOCK_RST = 4'hF;
	localparam logic [31:0] FG_ZERO32   = 32'h0000_0000;

	// ------------------------------------------------------------
	// core operations and guard states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FG_OP_ERASE   = 2'h0,
		FG_OP_WRITE   = 2'h1,
		FG_OP_BUFLOAD = 2'h2,
		FG_OP_READ    = 2'h3
	} fg_op_t;

	typedef enum logic [2:0] {
		FG_ST_IDLE = 3'h1,
		FG_ST_CRS  = 3'h2,
		FG_ST_HLT  = 3'h4
	} fg_state_t;

endpackage

// *** fg_flash_model.sv ***
// flash engine stand-in: answers each accepted start after a set delay
`timescale 1ns/100ps
`default_nettype none

module fg_flash_model
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// engine side
	input  wire logic [3:0] dly_i,
	input  wire logic       flash_start_i,
	output logic            flash_done_o
);
	logic [3:0] cnt_reg;
	logic       run_reg;

	// delay taken at start, so prompt and slow answers share one path
	always_ff @(posedge clk_i)
	begin
		flash_done_o <= 1'b0;
		if (rst_i)
		begin
			run_reg <= 1'b0;
			cnt_reg <= 4'h0;
		end
		else if (flash_start_i)
		begin
			run_reg <= 1'b1;
			cnt_reg <= dly_i;
		end
		else if (run_reg && cnt_reg == 4'h0)
		begin
			run_reg      <= 1'b0;
			flash_done_o <= 1'b1;
		end
		else if (run_reg)
			cnt_reg <= cnt_reg - 4'h1;
	end
endmodule // fg_flash_model
`default_nettype wire

// *** fg_guard_bench.sv ***
// self-checking bench for the flash access guard
`timescale 1ns/100ps
`default_nettype none

module fg_guard_bench
	import fg_pkg::*;
;
	logic clk, rst, cyc, stb, we, ack, op_req, exec_boot, done, start, erase, grant;
	logic chip_erase, ext_we, halt, fblock, iblock, busy, ce;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, rd;
	logic [1:0]  kind, bsz;
	logic [11:0] op_addr, fetch_addr, faddr;
	logic [3:0]  ext_dat, dly, lk, sel;
	logic [3:0]  lkv [4] = '{4'hF, 4'hA, 4'h0, 4'h5};
	int          error_cnt = 0;
	int          check_count = 0;
	int          i;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	fg_guard i_fg_guard (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.op_req_i(op_req), .op_kind_i(kind), .op_addr_i(op_addr), .exec_in_boot_i(exec_boot),
		.fetch_addr_i(fetch_addr), .flash_done_i(done), .flash_start_o(start),
		.flash_erase_o(erase), .flash_addr_o(faddr), .read_grant_o(grant),
		.boot_size_select_i(bsz), .chip_erase_i(chip_erase), .ext_lock_we_i(ext_we),
		.ext_lock_dat_i(ext_dat), .cpu_halt_o(halt), .fetch_block_o(fblock),
		.irq_block_o(iblock), .section_busy_flag_o(busy));

	fg_flash_model i_fg_flash_model (.clk_i(clk), .rst_i(rst), .dly_i(dly),
		.flash_start_i(start), .flash_done_o(done));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic hang(input string nm);
		$display("[ERR] %s expected answer seen none", nm);
		error_cnt++;
		give_verdict();
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
			error_cnt++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'hF;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (n == 20)
			hang("wishbone ack");
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		wb(1'b0, a, FG_ZERO32);
		chk(nm, exp, rd);
	endtask

	task automatic op(input logic [1:0] k, input logic [11:0] a, input logic bt);
		@(posedge clk);
		op_req    <= 1'b1;
		kind      <= k;
		op_addr   <= a;
		exec_boot <= bt;
		@(posedge clk);
		op_req  <= 1'b0;
		op_addr <= 12'h000;
		@(negedge clk);
	endtask

	task automatic wait_done();
		int n;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (done === 1'b1)
				break;
		end
		if (n == 40)
			hang("flash done");
		@(negedge clk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst, cyc, stb, we, op_req, exec_boot, chip_erase, ext_we} = 8'h80;
		{adr, wdat, kind, op_addr, fetch_addr, ext_dat, sel} = '0;
		dly = 4'hF;
		ce = 1'b1;
		bsz = 2'h3;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(FG_OFS_LOCK, {28'h0, FG_LOCK_RST}, "lock reset");
		rdc(FG_OFS_STAT, FG_ZERO32, "status reset");
		rdc(8'h0C, FG_ZERO32, "unmapped read");
		// concurrent section page write, slow engine
		op(FG_OP_WRITE, 12'h100, 1'b1);
		chk("start", 1, start);
		chk("latched addr", 12'h100, faddr);
		chk("erase flag", 0, erase);
		chk("halt", 0, halt);
		chk("busy", 1, busy);
		op(FG_OP_READ, 12'h100, 1'b1);
		chk("blocked load", 0, grant);
		op(FG_OP_READ, 12'hC40, 1'b1);
		chk("halting load", 1, grant);
		@(posedge clk);
		fetch_addr <= 12'h100;
		@(negedge clk);
		chk("fetch block", 1, fblock);
		@(posedge clk);
		fetch_addr <= 12'hC40;
		@(negedge clk);
		chk("fetch free", 0, fblock);
		wait_done();
		rdc(FG_OFS_STAT, 32'h11, "status busy");
		wb(1'b1, FG_OFS_CTRL, 32'h1);
		rdc(FG_OFS_STAT, 32'h10, "status reenabled");
		wb(1'b1, FG_OFS_STAT, 32'h18);
		op(FG_OP_ERASE, 12'h040, 1'b1);
		chk("erase flag", 1, erase);
		wait_done();
		op(FG_OP_BUFLOAD, 12'h040, 1'b1);
		chk("busy by bufload", 0, busy);
		op(FG_OP_READ, 12'h100, 1'b0);
		chk("load after clear", 1, grant);
		// halting section write, prompt engine
		dly <= 4'h1;
		op(FG_OP_WRITE, 12'hC40, 1'b1);
		chk("halt on", 1, halt);
		chk("busy off", 0, busy);
		wait_done();
		chk("halt off", 0, halt);
		// clock enable low freezes the guard
		@(posedge clk);
		ce <= 1'b0;
		op(FG_OP_WRITE, 12'h100, 1'b1);
		chk("frozen start", 0, start);
		chk("frozen busy", 0, busy);
		@(posedge clk);
		ce <= 1'b1;
		// the four lock modes of both fields
		for (i = 0; i < 4; i++)
		begin
			lk = lkv[i];
			@(posedge clk);
			chip_erase <= 1'b1;
			@(posedge clk);
			chip_erase <= 1'b0;
			ext_we     <= i[0];
			ext_dat    <= lk;
			@(posedge clk);
			ext_we <= 1'b0;
			if (!i[0])
				wb(1'b1, FG_OFS_LOCK, {28'h0, lk});
			wb(1'b1, FG_OFS_LOCK, 32'hF);
			rdc(FG_OFS_LOCK, {28'h0, lk}, "lock bits");
			op(FG_OP_WRITE, 12'hC40, 1'b1);
			chk("app store", lk[0], start);
			if (start === 1'b1)
				wait_done();
			op(FG_OP_WRITE, 12'hFC0, 1'b1);
			chk("boot store", lk[2], start);
			if (start === 1'b1)
				wait_done();
			op(FG_OP_READ, 12'hC40, 1'b1);
			chk("app load", lk[1], grant);
			op(FG_OP_READ, 12'hFC0, 1'b0);
			chk("boot load", lk[3], grant);
			op(FG_OP_READ, 12'hC40, 1'b0);
			chk("own load", 1, grant);
			wb(1'b1, FG_OFS_CTRL, 32'h2);
			rdc(FG_OFS_CTRL, 32'h2, "vector bit");
			chk("app irq block", !lk[1], iblock);
			wb(1'b1, FG_OFS_CTRL, 32'h0);
			op(FG_OP_READ, 12'hFC0, 1'b1);
			chk("boot irq block", !lk[3], iblock);
			rdc(FG_OFS_STAT, {27'h0, !(lk[1] & lk[3]), !(lk[0] & lk[2]), 3'h0}, "rejects");
			wb(1'b1, FG_OFS_STAT, 32'h18);
		end
		// largest boot section: 0xC40 now belongs to it
		@(posedge clk);
		bsz <= 2'h0;
		op(FG_OP_READ, 12'hC40, 1'b0);
		chk("resized boot load", 0, grant);
		give_verdict();
	end
endmodule // fg_guard_bench
`default_nettype wire
